// *** hw/sucs_defs.svh ***
// Purpose: Constants for the start-up and clock select unit
// Assumes: Included by bare name from hw/ sources
// Notes: Times in their own units, counts derived where used
`ifndef SUCS_DEFS_SVH
`define SUCS_DEFS_SVH

`define SUCS_RST_DELAY_MS 64
`define SUCS_LP_OSC_KHZ 128
`define SUCS_OSC_SETTLE_CYC 6
`define SUCS_CONFIG_CYC 21
`define SUCS_PROT_WINDOW 3'h4
`define SUCS_PROT_W 3
`define SUCS_DIV_RESET 4'h3
`define SUCS_DIV_MAX 4'h8
`define SUCS_DIV_W 4
`define SUCS_SRC_W 2
`define SUCS_TRIM_W 8
`define SUCS_DATA_W 8
`define SUCS_ADDR_W 2
`define SUCS_IDX_SRC 2'h0
`define SUCS_IDX_TRIM 2'h1
`define SUCS_IDX_DIV 2'h2
`define SUCS_SRC_PAD_W 6
`define SUCS_DIV_PAD_W 4

`endif

// *** hw/sucs_pkg.sv ***
// Purpose: Types for the start-up and clock select unit
// Assumes: sucs_defs.svh supplies widths
// Notes: Source codes follow the selection field encoding
`include "sucs_defs.svh"

package sucs_pkg;

    typedef enum logic [1:0] {
        SRC_OSC8 = 2'h0,
        SRC_LP = 2'h1,
        SRC_EXT = 2'h2,
        SRC_RSVD = 2'h3
    } src_t;

    typedef enum logic [1:0] {
        SLP_IDLE = 2'h0,
        SLP_ADC_NR = 2'h1,
        SLP_POWER_DOWN = 2'h2,
        SLP_STANDBY = 2'h3
    } sleep_t;

    typedef enum logic [2:0] {
        ST_HOLD,
        ST_RST_DELAY,
        ST_OSC_SETTLE,
        ST_CONFIG,
        ST_RUN,
        ST_SLEEP,
        ST_WAKE_SETTLE
    } state_t;

endpackage : sucs_pkg

// *** hw/sys_clock_prescaler.sv ***
// Purpose: Divides main clock ticks by a power of two
// Assumes: main_tick is a one-cycle pulse per main clock edge
// Notes: New code applied only at the end of an old period
`include "sucs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sys_clock_prescaler
    import sucs_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Control
    input wire logic hold_default,
    input wire logic load,
    input wire logic [`SUCS_DIV_W-1:0] load_code,
    input wire logic main_tick,
    // Output
    output logic sys_tick_ff,
    output logic [`SUCS_DIV_W-1:0] code_ff
);

    logic [CNT_W-1:0] cnt_ff;
    logic [`SUCS_DIV_W-1:0] pend_ff;
    logic pend_valid_ff;
    logic [CNT_W-1:0] period_mask;
    logic period_end;
    logic [CNT_W-1:0] nxt_cnt;

    assign period_mask = CNT_W'((1 << code_ff) - 1);
    assign period_end = main_tick && (cnt_ff == period_mask);
    assign nxt_cnt = period_end ? '0 : cnt_ff + CNT_W'(main_tick);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= '0;
            sys_tick_ff <= 1'b0;
            code_ff <= `SUCS_DIV_RESET;
            pend_ff <= `SUCS_DIV_RESET;
            pend_valid_ff <= 1'b0;
        end else if (hold_default) begin
            cnt_ff <= '0;
            sys_tick_ff <= 1'b0;
            code_ff <= `SUCS_DIV_RESET;
            pend_valid_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            sys_tick_ff <= period_end;
            // Switch only at a finished old period: no short pulse
            if (period_end && pend_valid_ff) begin
                code_ff <= pend_ff;
                pend_valid_ff <= load;
            end else if (load) begin
                pend_valid_ff <= 1'b1;
            end
            if (load) begin
                pend_ff <= load_code;
            end
        end
    end

endmodule : sys_clock_prescaler

`default_nettype wire

// *** hw/startup_and_clock_select_unit.sv ***
// Purpose: Start-up reset sequencing, main clock select, trim, prescaler
// Assumes: Oscillators arrive as one-cycle ticks synchronous to clock
// Notes: Clocks are modelled as tick pulses, not gated clock nets
//
// What this block does
// - Internal reset held until sequence completes
// - First step counts 64 ms of 128 kHz
// - Reset delay counted fully, supply ignored
// - Six calibrated oscillator cycles before use
// - Load configuration over 21 system cycles
// - After reset: 8 MHz source, divide by eight
// - Power-down wake counts six main cycles only
// - Other sleep wakes resume with no delay
// - Source register bits 7:2 read zero
// - Source codes: 00 osc, 01 low-power, 10 external
// - Source switch never glitches main clock
// - Factory trim loaded into trim during reset
// - Trim writable, 00 slowest, FF fastest
// - Prescaler register bits 7:4 read zero
// - Prescaler divides by two to the code
// - Prescaler code resets to divide by eight
// - Prescaler change produces no faster period
// - New rate active at the end of the old period
`include "sucs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module startup_and_clock_select_unit
    import sucs_pkg::*;
#(
    parameter int RESET_DELAY_TICKS = `SUCS_RST_DELAY_MS * `SUCS_LP_OSC_KHZ,
    parameter int OSC_SETTLE_TICKS = `SUCS_OSC_SETTLE_CYC,
    parameter int CONFIG_TICKS = `SUCS_CONFIG_CYC,
    parameter int DIV_CNT_W = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Reset sources and factory values
    input wire logic reset_source_active,
    input wire logic [`SUCS_TRIM_W-1:0] factory_trim,
    // Oscillator ticks
    input wire logic osc8_tick,
    input wire logic lp_osc_tick,
    input wire logic ext_clk_tick,
    // Sleep control
    input wire logic sleep_enter,
    input wire logic [1:0] sleep_mode,
    input wire logic wake_request,
    // Register port
    input wire logic [`SUCS_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [`SUCS_DATA_W-1:0] reg_wdata,
    input wire logic prot_unlock,
    output logic [`SUCS_DATA_W-1:0] reg_rdata_ff,
    // Clock and reset outputs
    output logic internal_reset_ff,
    output logic core_run_ff,
    output logic main_tick_ff,
    output logic sys_tick_ff,
    output logic [`SUCS_SRC_W-1:0] main_source_code_ff,
    output logic [`SUCS_TRIM_W-1:0] oscillator_trim_ff
);

    // Counter sized for the longest step, whichever it is
    localparam int SHORT_MAX = (OSC_SETTLE_TICKS > CONFIG_TICKS) ?
                               OSC_SETTLE_TICKS : CONFIG_TICKS;
    localparam int STEP_MAX = (RESET_DELAY_TICKS > SHORT_MAX) ?
                              RESET_DELAY_TICKS : SHORT_MAX;
    localparam int CNT_W = $clog2(STEP_MAX + 1);
    localparam logic [CNT_W-1:0] DLY_LAST = CNT_W'(RESET_DELAY_TICKS - 1);
    localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(OSC_SETTLE_TICKS - 1);
    localparam logic [CNT_W-1:0] CFG_LAST = CNT_W'(CONFIG_TICKS - 1);

    state_t state_ff;
    state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    src_t req_src_ff;
    src_t cur_src_ff;
    logic main_en_ff;
    logic powerdown_ff;
    logic [`SUCS_PROT_W-1:0] prot_cnt_ff;
    logic [`SUCS_DIV_W-1:0] div_code;
    logic sys_tick;

    // Tick of each source, indexed by source code
    logic [3:0] tick_vec;
    logic cur_tick;
    logic count_tick;
    logic count_last;
    logic [CNT_W-1:0] step_last;

    // Register decode
    logic sel_src;
    logic sel_trim;
    logic sel_div;
    logic prot_open;
    logic src_code_ok;
    logic div_code_ok;
    logic wr_src;
    logic wr_div;
    logic wr_trim;
    logic in_run;
    logic [`SUCS_DATA_W-1:0] rd_mux;

    // State decode
    logic in_hold;
    logic in_delay;
    logic in_settle;
    logic in_config;
    logic in_wake;
    logic nxt_hold;
    logic nxt_startup;
    logic cfg_done;
    logic wake_done;
    logic sleep_take;
    logic pd_request;
    logic src_switch;

    // State decode, shared by the processes below
    assign in_hold = (state_ff == ST_HOLD);
    assign in_delay = (state_ff == ST_RST_DELAY);
    assign in_settle = (state_ff == ST_OSC_SETTLE);
    assign in_config = (state_ff == ST_CONFIG);
    assign in_wake = (state_ff == ST_WAKE_SETTLE);
    assign cfg_done = in_config && count_last;
    assign wake_done = in_wake && count_last;
    assign sleep_take = in_run && sleep_enter;
    // Only power-down stops the oscillator
    assign pd_request = (sleep_t'(sleep_mode) == SLP_POWER_DOWN);
    assign nxt_hold = (nxt_state == ST_HOLD);
    // Startup steps keep reset on until the config step ends
    assign nxt_startup = nxt_hold ||
                         (nxt_state == ST_RST_DELAY) ||
                         (nxt_state == ST_OSC_SETTLE) ||
                         (nxt_state == ST_CONFIG);
    // Old source edge is the only safe hand-over point
    assign src_switch = cur_tick && (cur_src_ff != req_src_ff);

    assign tick_vec = {1'b0, ext_clk_tick, lp_osc_tick, osc8_tick};
    assign cur_tick = tick_vec[cur_src_ff];

    // Each step counts its own time base
    assign count_tick = in_delay ? lp_osc_tick :
                        in_settle ? osc8_tick :
                        in_config ? sys_tick :
                        cur_tick;
    assign step_last = in_delay ? DLY_LAST :
                       in_config ? CFG_LAST : OSC_LAST;
    assign count_last = count_tick && (cnt_ff == step_last);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ST_HOLD: begin
                nxt_cnt = '0;
                if (!reset_source_active) begin
                    nxt_state = ST_RST_DELAY;
                end
            end
            ST_RST_DELAY, ST_OSC_SETTLE, ST_CONFIG, ST_WAKE_SETTLE: begin
                // No supply check: the full count always runs
                nxt_cnt = cnt_ff + CNT_W'(count_tick);
                if (count_last) begin
                    nxt_cnt = '0;
                    if (state_ff == ST_RST_DELAY) begin
                        nxt_state = ST_OSC_SETTLE;
                    end else if (state_ff == ST_OSC_SETTLE) begin
                        nxt_state = ST_CONFIG;
                    end else begin
                        nxt_state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (sleep_enter) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                nxt_cnt = '0;
                if (wake_request) begin
                    // Oscillator still running except in power-down
                    nxt_state = powerdown_ff ? ST_WAKE_SETTLE : ST_RUN;
                end
            end
        endcase
        if (reset_source_active) begin
            nxt_state = ST_HOLD;
            nxt_cnt = '0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_HOLD;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Reset stays on until the last configuration tick
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            internal_reset_ff <= 1'b1;
            core_run_ff <= 1'b0;
        end else begin
            internal_reset_ff <= nxt_startup;
            core_run_ff <= (nxt_state == ST_RUN);
        end
    end

    // Power-down stops the main clock until the settle count ends
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            powerdown_ff <= 1'b0;
            main_en_ff <= 1'b1;
        end else begin
            if (sleep_take) begin
                powerdown_ff <= pd_request;
            end
            if (nxt_hold) begin
                main_en_ff <= 1'b1;
            end else if (sleep_take) begin
                main_en_ff <= !pd_request;
            end else if (wake_done) begin
                main_en_ff <= 1'b1;
            end
        end
    end

    // Register decode and protected writes
    assign in_run = (state_ff == ST_RUN);
    assign sel_src = (reg_addr == `SUCS_IDX_SRC);
    assign sel_trim = (reg_addr == `SUCS_IDX_TRIM);
    assign sel_div = (reg_addr == `SUCS_IDX_DIV);
    assign prot_open = (prot_cnt_ff != '0);
    assign src_code_ok = (src_t'(reg_wdata[`SUCS_SRC_W-1:0]) != SRC_RSVD);
    assign div_code_ok = (reg_wdata[`SUCS_DIV_W-1:0] <= `SUCS_DIV_MAX);
    assign wr_src = in_run && reg_wr && sel_src && prot_open &&
                    src_code_ok;
    assign wr_div = in_run && reg_wr && sel_div && prot_open &&
                    div_code_ok;
    assign wr_trim = in_run && reg_wr && sel_trim;

    // Window of four instruction cycles after the unlock signature
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prot_cnt_ff <= '0;
        end else if (!in_run || wr_src || wr_div) begin
            prot_cnt_ff <= '0;
        end else if (prot_unlock) begin
            prot_cnt_ff <= `SUCS_PROT_WINDOW;
        end else if (sys_tick && prot_open) begin
            prot_cnt_ff <= prot_cnt_ff - `SUCS_PROT_W'(1);
        end
    end

    // Source request and trim
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            req_src_ff <= SRC_OSC8;
            oscillator_trim_ff <= '0;
        end else begin
            if (nxt_hold) begin
                req_src_ff <= SRC_OSC8;
            end else if (wr_src) begin
                req_src_ff <= src_t'(reg_wdata[`SUCS_SRC_W-1:0]);
            end
            if (cfg_done) begin
                oscillator_trim_ff <= factory_trim;
            end else if (wr_trim) begin
                oscillator_trim_ff <= reg_wdata;
            end
        end
    end

    // Hand over only on an edge of the old source: no runt period
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cur_src_ff <= SRC_OSC8;
            main_tick_ff <= 1'b0;
        end else begin
            if (nxt_hold) begin
                cur_src_ff <= SRC_OSC8;
            end else if (src_switch) begin
                cur_src_ff <= req_src_ff;
            end
            main_tick_ff <= cur_tick && main_en_ff;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            main_source_code_ff <= SRC_OSC8;
        end else begin
            main_source_code_ff <= cur_src_ff;
        end
    end

    sys_clock_prescaler #(
        .CNT_W(DIV_CNT_W)
    ) u_prescaler (
        .clock(clock),
        .arst_n(arst_n),
        .hold_default(in_hold),
        .load(wr_div),
        .load_code(reg_wdata[`SUCS_DIV_W-1:0]),
        .main_tick(main_tick_ff),
        .sys_tick_ff(sys_tick),
        .code_ff(div_code)
    );

    assign sys_tick_ff = sys_tick;

    // Reserved bits and unmapped indexes read as zero
    assign rd_mux = sel_src ? {`SUCS_SRC_PAD_W'(0), req_src_ff} :
                    sel_trim ? oscillator_trim_ff :
                    sel_div ? {`SUCS_DIV_PAD_W'(0), div_code} :
                    '0;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_ff <= '0;
        end else begin
            reg_rdata_ff <= rd_mux;
        end
    end

endmodule : startup_and_clock_select_unit

`default_nettype wire

// *** test/sucs_chk.sv ***
// Purpose: Port-level checks for the start-up and clock select unit
// Assumes: Bound to the top module, single clock domain
// Notes: Power-down settle bound assumes ticks at least a cycle apart
`timescale 1ns/1ps
`default_nettype none

module sucs_chk #(
    parameter int RESET_DELAY_TICKS = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Inputs
    input wire logic reset_source_active,
    input wire logic [7:0] factory_trim,
    input wire logic lp_osc_tick,
    input wire logic sleep_enter,
    input wire logic [1:0] sleep_mode,
    input wire logic wake_request,
    input wire logic [1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    // Outputs
    input wire logic [7:0] reg_rdata_ff,
    input wire logic internal_reset_ff,
    input wire logic core_run_ff,
    input wire logic [1:0] main_source_code_ff,
    input wire logic [7:0] oscillator_trim_ff
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    int lp_seen_ff;
    logic pd_ff;

    // Overcounts ticks of later steps, so only a lower bound is safe
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lp_seen_ff <= 0;
            pd_ff <= 1'b0;
        end else begin
            if (reset_source_active || !internal_reset_ff) begin
                lp_seen_ff <= 0;
            end else if (lp_osc_tick && lp_seen_ff < 65535) begin
                lp_seen_ff <= lp_seen_ff + 1;
            end
            if (sleep_enter && core_run_ff) begin
                pd_ff <= (sleep_mode == 2'h2);
            end
        end
    end

    sequence pd_settle_hold;
        !core_run_ff [*5];
    endsequence

    a_rst_on_source: assert property (reset_source_active |=> internal_reset_ff)
        else $error("internal reset missed a reset source");
    a_rst_delay_full: assert property ($fell(internal_reset_ff) |-> lp_seen_ff >= RESET_DELAY_TICKS)
        else $error("reset released before the delay count");
    a_src_in_rst: assert property (internal_reset_ff ##1 internal_reset_ff |-> main_source_code_ff == 2'h0)
        else $error("main source not default during reset");
    a_src_no_rsvd: assert property (main_source_code_ff != 2'h3)
        else $error("reserved main source active");
    a_trim_load: assert property ($fell(internal_reset_ff) |-> oscillator_trim_ff == $past(factory_trim))
        else $error("factory trim not loaded");
    a_trim_write: assert property (core_run_ff && reg_wr && reg_addr == 2'h1 |=> oscillator_trim_ff == $past(reg_wdata))
        else $error("trim write lost");
    a_fast_wake: assert property (wake_request && !core_run_ff && !internal_reset_ff && !pd_ff |=> core_run_ff)
        else $error("light sleep wake delayed");
    a_pd_settle: assert property (wake_request && !core_run_ff && !internal_reset_ff && pd_ff |=> pd_settle_hold ##[1:1000] core_run_ff)
        else $error("power-down wake settle wrong");
    a_src_rsvd_zero: assert property (reg_addr == 2'h0 |=> reg_rdata_ff[7:2] == 6'h00)
        else $error("source register upper bits set");
    a_div_rsvd_zero: assert property (reg_addr == 2'h2 |=> reg_rdata_ff[7:4] == 4'h0 && reg_rdata_ff[3:0] <= 4'h8)
        else $error("divider register read bad");
endmodule : sucs_chk

bind startup_and_clock_select_unit sucs_chk #(
    .RESET_DELAY_TICKS(RESET_DELAY_TICKS)
) sucs_chk_i (
    .clock(clock), .arst_n(arst_n), .reset_source_active(reset_source_active),
    .factory_trim(factory_trim), .lp_osc_tick(lp_osc_tick),
    .sleep_enter(sleep_enter), .sleep_mode(sleep_mode),
    .wake_request(wake_request), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .internal_reset_ff(internal_reset_ff), .core_run_ff(core_run_ff),
    .main_source_code_ff(main_source_code_ff),
    .oscillator_trim_ff(oscillator_trim_ff)
);
`default_nettype wire

// *** test/test_startup_and_clock_select_unit.sv ***
// Purpose: Self-checking bench for the start-up and clock select unit
// Assumes: Ticks at 1/5, 1/8, 1/3 of the 40 MHz clock
// Notes: Reset delay shortened to 8 low-power ticks
`timescale 1ns/1ps
`default_nettype none

module test_startup_and_clock_select_unit;
    localparam int RST_T = 8;
    localparam int MIN_START = 870;
    localparam int LIMIT = 30000;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic reset_source_active = 1'b0;
    logic [7:0] factory_trim = 8'h5A;
    logic osc8_tick = 1'b0;
    logic lp_osc_tick = 1'b0;
    logic ext_clk_tick = 1'b0;
    logic sleep_enter = 1'b0;
    logic [1:0] sleep_mode = 2'h0;
    logic wake_request = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic prot_unlock = 1'b0;
    logic [7:0] reg_rdata_ff;
    logic internal_reset_ff;
    logic core_run_ff;
    logic main_tick_ff;
    logic sys_tick_ff;
    logic [1:0] main_source_code_ff;
    logic [7:0] oscillator_trim_ff;
    logic [7:0] rd_v;
    logic [1:0] s;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    always #12.5 clock = ~clock;

    startup_and_clock_select_unit #(
        .RESET_DELAY_TICKS(RST_T)
    ) startup_and_clock_select_unit_i (
        .clock(clock), .arst_n(arst_n),
        .reset_source_active(reset_source_active),
        .factory_trim(factory_trim), .osc8_tick(osc8_tick),
        .lp_osc_tick(lp_osc_tick), .ext_clk_tick(ext_clk_tick),
        .sleep_enter(sleep_enter), .sleep_mode(sleep_mode),
        .wake_request(wake_request), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .prot_unlock(prot_unlock),
        .reg_rdata_ff(reg_rdata_ff), .internal_reset_ff(internal_reset_ff),
        .core_run_ff(core_run_ff), .main_tick_ff(main_tick_ff),
        .sys_tick_ff(sys_tick_ff), .main_source_code_ff(main_source_code_ff),
        .oscillator_trim_ff(oscillator_trim_ff)
    );

    // Oscillator ticks and the hang guard
    always @(posedge clock) begin
        cyc <= cyc + 1;
        osc8_tick <= (cyc % 5 == 0);
        lp_osc_tick <= (cyc % 8 == 0);
        ext_clk_tick <= (cyc % 3 == 0);
        if (cyc == LIMIT) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic unl);
        @(posedge clock);
        prot_unlock <= unl;
        @(posedge clock);
        prot_unlock <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1;
        chk(16'(reg_rdata_ff), 16'(e));
    endtask : rd

    // Cycles from one tick to the next, waiting first for a tick
    task automatic gap(input logic sys, output int g);
        int k;
        k = 0;
        g = 0;
        #1;
        while ((sys ? sys_tick_ff : main_tick_ff) !== 1'b1 && k < 3000) begin
            @(posedge clock);
            #1;
            k++;
        end
        do begin
            @(posedge clock);
            #1;
            g++;
        end while ((sys ? sys_tick_ff : main_tick_ff) !== 1'b1 && g < 3000);
    endtask : gap

    task automatic after_start(input logic [7:0] trim);
        int k;
        k = 0;
        while (internal_reset_ff !== 1'b0 && k < 5000) begin
            @(posedge clock);
            #1;
            k++;
        end
        chk(16'(k >= MIN_START && k < 5000), 16'h1);
        chk(16'(oscillator_trim_ff), 16'(trim));
        rd(2'h0, 8'h00);
        rd(2'h2, 8'h03);
        gap(1'b0, n);
        chk(16'(n), 16'h5);
        gap(1'b1, n);
        gap(1'b1, n);
        chk(16'(n), 16'h28);
    endtask : after_start

    task automatic nap(input logic [1:0] m);
        int k;
        int t;
        k = 0;
        t = 0;
        @(posedge clock);
        sleep_mode <= m;
        sleep_enter <= 1'b1;
        @(posedge clock);
        sleep_enter <= 1'b0;
        repeat (2) @(posedge clock);
        repeat (20) begin
            @(posedge clock);
            #1;
            t = t + int'(main_tick_ff === 1'b1);
        end
        chk(16'(core_run_ff), 16'h0);
        if (m == 2'h2) chk(16'(t), 16'h0);
        @(posedge clock);
        wake_request <= 1'b1;
        @(posedge clock);
        wake_request <= 1'b0;
        #1;
        while (core_run_ff !== 1'b1 && k < 200) begin
            @(posedge clock);
            #1;
            k++;
        end
        // Six ticks five cycles apart in power-down, none otherwise
        if (m == 2'h2) chk(16'(k >= 24 && k <= 36), 16'h1);
        else chk(16'(k), 16'h0);
    endtask : nap

    initial begin
        repeat (16) @(posedge clock);
        #1;
        chk(16'(internal_reset_ff), 16'h1);
        @(posedge clock);
        arst_n <= 1'b1;
        after_start(8'h5A);
        wr(2'h2, 8'h01, 1'b0);
        rd(2'h2, 8'h03);
        wr(2'h2, 8'h09, 1'b1);
        rd(2'h2, 8'h03);
        for (int c = 8; c >= 0; c--) begin
            wr(2'h2, 8'(c), 1'b1);
            gap(1'b1, n);
            gap(1'b1, n);
            chk(16'(n), 16'(5 << c));
            rd(2'h2, 8'(c));
        end
        for (int i = 0; i < 2; i++) begin
            s = i ? 2'h1 : 2'h2;
            wr(2'h0, {6'h00, s}, 1'b1);
            repeat (40) @(posedge clock);
            #1;
            chk(16'(main_source_code_ff), 16'(s));
            rd(2'h0, {6'h00, s});
            gap(1'b0, n);
            gap(1'b0, n);
            chk(16'(n), i ? 16'h8 : 16'h3);
        end
        // Unprotected first: a refused code leaves the window open
        wr(2'h0, 8'h02, 1'b0);
        wr(2'h0, 8'h03, 1'b1);
        wr(2'h3, 8'hFF, 1'b1);
        repeat (40) @(posedge clock);
        rd(2'h0, 8'h01);
        for (int i = 0; i < 2; i++) begin
            wr(2'h1, i ? 8'hFF : 8'h00, 1'b0);
            rd(2'h1, i ? 8'hFF : 8'h00);
        end
        @(posedge clock);
        reset_source_active <= 1'b1;
        factory_trim <= 8'hA5;
        @(posedge clock);
        #1;
        chk(16'(internal_reset_ff), 16'h1);
        repeat (20) @(posedge clock);
        reset_source_active <= 1'b0;
        after_start(8'hA5);
        for (int m = 0; m < 4; m++) begin
            nap(2'(m));
        end
        summarize();
    end
endmodule : test_startup_and_clock_select_unit
`default_nettype wire
